/* bench/flash_dev_model.sv */
// behavioural byte-wide flash device facing the host controller
`timescale 1ns/100ps
// command codes are arbitrary, the host passes them through as plain bytes
module flash_dev_model #(
  parameter logic [7:0] PROG_CMD = 8'h50,
  parameter logic [7:0] ERASE_CMD = 8'h51,
  parameter logic [7:0] CONFIRM_CMD = 8'h52,
  parameter logic [7:0] SUSP_CMD = 8'h53,
  parameter logic [7:0] RESUME_CMD = 8'h54,
  parameter logic [7:0] LOCK_CMD = 8'h55,
  parameter logic [7:0] SET_BLK_CMD = 8'h56,
  parameter logic [7:0] SET_MASTER_CMD = 8'h57,
  parameter logic [7:0] CLR_LOCK_CMD = 8'h58,
  parameter int BUSY_NS = 2000,
  parameter int WAKE_NS = 1000
)
(
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n,
  output logic [7:0] flash_dq_i,
  output logic ready_busy_out
);
  logic [7:0] mem [logic [20:0]];
  logic [7:0] rd_val;
  logic [7:0] pend = 8'h00;
  logic [31:0] lock_q = 32'h00000000;
  logic master_q = 1'b0;
  logic held = 1'b0;
  logic [4:0] op_blk = 5'h00;
  logic [4:0] blk;
  assign blk = flash_addr[20:16];
  logic busy = 1'b0;
  int fault_cnt = 0;
  realtime wake_at = 0;
  always @(negedge reset_powerdown_n)
  begin
    pend = 8'h00;
    busy = 1'b0;
    held = 1'b0;
  end
  always @(posedge reset_powerdown_n)
    wake_at = $realtime;
  // address and data taken on the rising strobe only
  always @(posedge write_enable_n)
  begin
    if (reset_powerdown_n === 1'b1 && chip_select_n === 1'b0)
    begin
      if ($realtime - wake_at < WAKE_NS)
        fault_cnt++;
      else if (busy)
      begin
        // only a suspend may reach a running state machine
        if (flash_dq_o == SUSP_CMD)
        begin
          held = 1'b1;
          busy = 1'b0;
        end
        else
          fault_cnt++;
      end
      else if (held && flash_dq_o == RESUME_CMD)
      begin
        held = 1'b0;
        busy = 1'b1;
      end
      else if (pend == PROG_CMD)
      begin
        // locked or suspended blocks keep their contents
        if (!lock_q[blk] && !(held && blk == op_blk))
        begin
          mem[flash_addr] = flash_dq_o;
          op_blk = held ? op_blk : blk;
          busy = 1'b1;
        end
        pend = 8'h00;
      end
      else if (pend == ERASE_CMD && flash_dq_o == CONFIRM_CMD)
      begin
        if (!lock_q[blk] && !held)
        begin
          for (int i = 0; i < 65536; i++)
            mem.delete({blk, 16'(i)});
          op_blk = blk;
          busy = 1'b1;
        end
        pend = 8'h00;
      end
      else if (pend == LOCK_CMD)
      begin
        // the master bit freezes the block bits once set
        if (flash_dq_o == SET_MASTER_CMD)
          master_q = 1'b1;
        else if (!master_q && flash_dq_o == SET_BLK_CMD)
          lock_q[blk] = 1'b1;
        else if (!master_q && flash_dq_o == CLR_LOCK_CMD)
          lock_q = 32'h00000000;
        busy = 1'b1;
        pend = 8'h00;
      end
      else
        pend = flash_dq_o;
    end
  end
  // a timer cut short by power-down may end a later operation early
  always @(posedge busy)
  begin
    #(BUSY_NS);
    busy = 1'b0;
  end
  assign ready_busy_out = !(busy && reset_powerdown_n);
  always @(flash_addr or busy or output_enable_n)
    rd_val = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
  // no pull on the bus: released lines show the inverse value
  assign flash_dq_i = (!chip_select_n && !output_enable_n && reset_powerdown_n) ? rd_val : ~rd_val;
endmodule

/* bench/flash_host_checker.sv */
// pin and apb port assertions for the flash host controller
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_host_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n
);
  localparam int WAKE_CYC = `WAKE_WRITE_CYCLES;
  localparam int REC_CYC = `RESET_RECOVERY_CYCLES;
  logic [5:0] awake_q;
  logic [5:0] awake_d;
  logic mapped;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // cycles since power-down ended, saturating
  // ----------------------------------------
  always_comb
  begin
    awake_d = awake_q;
    if (!reset_powerdown_n)
      awake_d = 6'h00;
    else if (awake_q != 6'h3f)
      awake_d = awake_q + 6'h01;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      awake_q <= 6'h00;
    else
      awake_q <= awake_d;
  end
  assign mapped = paddr inside {`REG_CTRL, `REG_ADDR, `REG_WDATA, `REG_RDATA, `REG_STATUS};
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pready_const: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
  a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_strobe_selected: assert property (!write_enable_n |-> !chip_select_n && output_enable_n)
    else $error("strobe without select");
  a_strobe_width: assert property ($fell(write_enable_n) |=> !write_enable_n ##1 write_enable_n)
    else $error("strobe width wrong");
  a_strobe_hold: assert property ($rose(write_enable_n) |-> flash_dq_oe && $stable(flash_dq_o)
    && $stable(flash_addr)) else $error("data moved at strobe edge");
  a_wake_write: assert property (!write_enable_n |-> awake_q >= WAKE_CYC)
    else $error("write before wake time");
  a_recover_read: assert property (!output_enable_n |-> awake_q >= REC_CYC)
    else $error("read before recovery time");
  a_pd_quiet: assert property (!reset_powerdown_n |-> chip_select_n && write_enable_n)
    else $error("pins active in power-down");
  a_no_contend: assert property (flash_dq_oe |-> output_enable_n) else $error("data bus contention");
  c_write: cover property ($fell(write_enable_n));
  c_read: cover property ($fell(output_enable_n));
  c_pd: cover property ($fell(reset_powerdown_n));
  c_err: cover property (psel && penable && pslverr);
endmodule

/* bench/tb.sv */
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module tb
  import flash_host_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, dq_oe, cs_n, oe_n, we_n, rp_n, rdy;
  logic [20:0] fa;
  logic [7:0] dq_i, dq_o;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 clock = ~clock;
  flash_host_ctrl dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
    .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .reset_powerdown_n(rp_n), .ready_busy_out(rdy));
  flash_dev_model dev_u (.flash_addr(fa), .flash_dq_o(dq_o), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .reset_powerdown_n(rp_n), .flash_dq_i(dq_i), .ready_busy_out(rdy));
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ----------------------------------------
  // apb transfers, held until pready
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, `REG_STATUS, 32'h0);
    while (q[b] !== v && n < 100)
    begin
      n++;
      apb(1'b0, `REG_STATUS, 32'h0);
    end
    check("status poll", {31'h0, q[b]}, {31'h0, v});
  endtask
  task automatic go(input op_t op, input logic w);
    apb(1'b1, `REG_CTRL, {28'h0, w, 1'b1, op});
  endtask
  task automatic run(input op_t op, input logic w);
    go(op, w);
    poll(`ST_DONE_BIT, 1'b1);
    apb(1'b1, `REG_STATUS, 32'h60);
  endtask
  task automatic cmd(input logic [20:0] a, input logic [7:0] d, input logic w);
    apb(1'b1, `REG_ADDR, {11'h0, a});
    apb(1'b1, `REG_WDATA, {24'h0, d});
    run(OP_WRITE, w);
  endtask
  task automatic prog(input logic [20:0] a, input logic [7:0] d);
    cmd(a, dev_u.PROG_CMD, 1'b1);
    cmd(a, d, 1'b1);
  endtask
  task automatic lock(input logic [20:0] a, input logic [7:0] c);
    cmd(a, dev_u.LOCK_CMD, 1'b1);
    cmd(a, c, 1'b1);
  endtask
  task automatic fread(input logic [20:0] a);
    apb(1'b1, `REG_ADDR, {11'h0, a});
    run(OP_READ, 1'b0);
    apb(1'b0, `REG_RDATA, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0);
    check("idle status", q & 32'h7, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped read", {q[30:0], e}, 32'h1);
    apb(1'b1, `REG_ADDR, 32'h001f0010);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("block index", {27'h0, q[12:8]}, 32'h1f);
    prog(21'h1f0010, 8'ha5);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("busy seen", {31'h0, q[1]}, 32'h0);
    prog(21'h000003, 8'h3c);
    fread(21'h1f0010);
    check("read a", q, 32'ha5);
    fread(21'h000003);
    check("read b", q, 32'h3c);
    fread(21'h1f0011);
    check("untouched byte", q, 32'hff);
    cmd(21'h1f0000, dev_u.ERASE_CMD, 1'b1);
    cmd(21'h1f0000, dev_u.CONFIRM_CMD, 1'b1);
    // suspend lands while the erase still runs, so no ready wait
    cmd(21'h1f0000, dev_u.SUSP_CMD, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("ready in erase suspend", {31'h0, q[1]}, 32'h1);
    prog(21'h010000, 8'h77);
    fread(21'h010000);
    check("program in erase suspend", q, 32'h77);
    fread(21'h000003);
    check("read in erase suspend", q, 32'h3c);
    cmd(21'h1f0000, dev_u.RESUME_CMD, 1'b1);
    fread(21'h1f0010);
    check("erased byte", q, 32'hff);
    prog(21'h000005, 8'h11);
    cmd(21'h000005, dev_u.SUSP_CMD, 1'b0);
    fread(21'h000003);
    check("read in program suspend", q, 32'h3c);
    cmd(21'h000005, dev_u.RESUME_CMD, 1'b1);
    lock(21'h010000, dev_u.SET_BLK_CMD);
    prog(21'h010001, 8'h22);
    fread(21'h010001);
    check("locked block", q, 32'hff);
    lock(21'h010000, dev_u.CLR_LOCK_CMD);
    prog(21'h010001, 8'h22);
    fread(21'h010001);
    check("cleared lock", q, 32'h22);
    lock(21'h010000, dev_u.SET_BLK_CMD);
    lock(21'h010000, dev_u.SET_MASTER_CMD);
    lock(21'h010000, dev_u.CLR_LOCK_CMD);
    prog(21'h010002, 8'h33);
    fread(21'h010002);
    check("master lock", q, 32'hff);
    go(OP_POWERDOWN, 1'b0);
    poll(`ST_POWERDOWN_BIT, 1'b1);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("ready in power-down", {31'h0, q[1]}, 32'h1);
    go(OP_READ, 1'b0);
    poll(`ST_ERROR_BIT, 1'b1);
    apb(1'b1, `REG_STATUS, 32'h60);
    go(OP_WAKE, 1'b0);
    poll(`ST_POWERDOWN_BIT, 1'b0);
    apb(1'b1, `REG_STATUS, 32'h60);
    prog(21'h0a0000, 8'h5a);
    fread(21'h0a0000);
    check("read after wake", q, 32'h5a);
    check("device faults", 32'(dev_u.fault_cnt), 32'h0);
    results;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results;
    end
  end
endmodule
bind flash_host_ctrl flash_host_checker chk_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .reset_powerdown_n(reset_powerdown_n));

/* design/flash_cycle_if.sv */
// one bus cycle request between the controller and the pin engine
`timescale 1ns/100ps
interface flash_cycle_if;
  logic req;
  logic write;
  logic [20:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport ctrl (output req, output write, output addr, output wdata, input done, input rdata);
  modport engine (input req, input write, input addr, input wdata, output done, output rdata);
endinterface

/* design/flash_host_ctrl.sv */
// flash host controller: apb register slave that sequences the flash pins
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic reset_powerdown_n,
  input wire logic ready_busy_out
);

  localparam logic [7:0] RECOVERY_CNT = 8'(`RESET_RECOVERY_CYCLES);
  localparam logic [7:0] WAKE_CNT = 8'(`WAKE_WRITE_CYCLES);

  flash_cycle_if cyc_if ();

  ctrl_state_t state_q, state_d;
  op_t op_q, op_d;
  logic wait_ready_q, wait_ready_d;
  logic [20:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic error_q, error_d;
  logic pd_q, pd_d;
  logic [7:0] wake_cnt_q, wake_cnt_d;
  logic [31:0] prdata_q, prdata_d;

  logic access;
  logic wr_access;
  logic mapped;
  logic go;
  op_t go_op;
  logic read_ok;
  logic write_ok;
  logic gate_ok;
  logic [31:0] status_word;
  logic [31:0] read_word;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign access = psel && penable;
  assign wr_access = access && pwrite;
  assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_ADDR) || (paddr == `REG_WDATA)
                  || (paddr == `REG_RDATA) || (paddr == `REG_STATUS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign go = wr_access && (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT];
  assign go_op = op_t'(pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);

  // ----------------------------------------
  // release timers
  // ----------------------------------------
  // the count restarts on every release, so a short power-down still pays the full wake time
  assign read_ok = !pd_q && (wake_cnt_q >= RECOVERY_CNT);
  assign write_ok = !pd_q && (wake_cnt_q >= WAKE_CNT);
  // a read may follow the wake without a mode command, the device comes up reading the array
  assign gate_ok = ((op_q == OP_READ) ? read_ok : write_ok)
                   && (!wait_ready_q || ready_busy_out);

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[`ST_BUSY_BIT] = (state_q != S_IDLE);
    status_word[`ST_READY_BIT] = ready_busy_out;
    status_word[`ST_POWERDOWN_BIT] = pd_q;
    status_word[`ST_WRITE_OK_BIT] = write_ok;
    status_word[`ST_READ_OK_BIT] = read_ok;
    status_word[`ST_DONE_BIT] = done_q;
    status_word[`ST_ERROR_BIT] = error_q;
    status_word[`ST_BLOCK_MSB:`ST_BLOCK_LSB] = addr_q[20:`BLOCK_OFFSET_BITS];
  end

  always_comb
  begin
    case (paddr)
      `REG_CTRL:
      begin
        read_word = {28'h0000000, wait_ready_q, 1'b0, op_q};
      end
      `REG_ADDR:
      begin
        read_word = {11'h000, addr_q};
      end
      `REG_WDATA:
      begin
        read_word = {24'h000000, wdata_q};
      end
      `REG_RDATA:
      begin
        read_word = {24'h000000, rdata_q};
      end
      `REG_STATUS:
      begin
        read_word = status_word;
      end
      default:
      begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------
  // control sequencer and registers
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    wait_ready_d = wait_ready_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = done_q;
    error_d = error_q;
    pd_d = pd_q;
    wake_cnt_d = wake_cnt_q;
    prdata_d = prdata_q;

    if (psel && !penable && !pwrite)
    begin
      prdata_d = read_word;
    end

    // write-one clears, applied first so that a new event below wins
    if (wr_access && (paddr == `REG_STATUS))
    begin
      if (pwdata[`ST_DONE_BIT])
      begin
        done_d = 1'b0;
      end
      if (pwdata[`ST_ERROR_BIT])
      begin
        error_d = 1'b0;
      end
    end

    // operands are frozen while an operation is in flight
    if (wr_access && (paddr == `REG_ADDR) && (state_q == S_IDLE))
    begin
      addr_d = pwdata[20:0];
    end
    if (wr_access && (paddr == `REG_WDATA) && (state_q == S_IDLE))
    begin
      wdata_d = pwdata[7:0];
    end

    if (!pd_q && (wake_cnt_q != WAKE_CNT))
    begin
      wake_cnt_d = wake_cnt_q + 8'h01;
    end

    case (state_q)
      S_IDLE:
      begin
        if (go)
        begin
          op_d = go_op;
          wait_ready_d = pwdata[`CTRL_WAIT_READY_BIT];
          case (go_op)
            OP_POWERDOWN:
            begin
              pd_d = 1'b1;
              wake_cnt_d = 8'h00;
              done_d = 1'b1;
            end
            OP_WAKE:
            begin
              pd_d = 1'b0;
              wake_cnt_d = pd_q ? 8'h00 : wake_cnt_q;
              done_d = 1'b1;
            end
            default:
            begin
              if (pd_q)
              begin
                error_d = 1'b1;
              end
              else
              begin
                state_d = S_WAIT;
              end
            end
          endcase
        end
      end
      S_WAIT:
      begin
        if (gate_ok)
        begin
          state_d = S_CYCLE;
        end
      end
      S_CYCLE:
      begin
        if (cyc_if.done)
        begin
          if (op_q == OP_READ)
          begin
            rdata_d = cyc_if.rdata;
          end
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase

    if (go && (state_q != S_IDLE))
    begin
      error_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      op_q <= OP_WRITE;
      wait_ready_q <= 1'b0;
      addr_q <= `ADDR_RESET;
      wdata_q <= `WDATA_RESET;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      error_q <= 1'b0;
      pd_q <= 1'b0;
      wake_cnt_q <= 8'h00;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      wait_ready_q <= wait_ready_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      error_q <= error_d;
      pd_q <= pd_d;
      wake_cnt_q <= wake_cnt_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // pin engine
  // ----------------------------------------
  assign cyc_if.req = (state_q == S_CYCLE);
  assign cyc_if.write = (op_q == OP_WRITE);
  assign cyc_if.addr = addr_q;
  assign cyc_if.wdata = wdata_q;

  flash_pin_engine u_engine (
    .clock(clock),
    .rst_n(rst_n),
    .cyc(cyc_if.engine),
    .flash_addr(flash_addr),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n)
  );

  assign reset_powerdown_n = !pd_q;
  assign prdata = prdata_q;

endmodule

/* design/flash_host_defines.svh */
// register offsets, field positions, reset values and timing counts of the flash host controller
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0c
`define REG_STATUS 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 1
`define CTRL_GO_BIT 2
`define CTRL_WAIT_READY_BIT 3
`define ST_BUSY_BIT 0
`define ST_READY_BIT 1
`define ST_POWERDOWN_BIT 2
`define ST_WRITE_OK_BIT 3
`define ST_READ_OK_BIT 4
`define ST_DONE_BIT 5
`define ST_ERROR_BIT 6
`define ST_BLOCK_LSB 8
`define ST_BLOCK_MSB 12
`define FLASH_ADDR_BITS 21
`define FLASH_DATA_BITS 8
`define BLOCK_OFFSET_BITS 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADDR_RESET 21'h000000
`define WDATA_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define RESET_RECOVERY_TIME_NS 100
`define WAKE_WRITE_TIME_NS 1000
`define ADDR_SETUP_NS 50
`define WE_PULSE_NS 100
`define READ_ACCESS_NS 150
`define RESET_RECOVERY_CYCLES ((`RESET_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_WRITE_CYCLES ((`WAKE_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_SETUP_CYCLES ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_CYCLES ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYCLES ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* design/flash_host_pkg.sv */
// types shared by the flash host controller and its pin engine
package flash_host_pkg;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_POWERDOWN = 2'b10,
    OP_WAKE = 2'b11
  } op_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_CYCLE = 2'b10
  } ctrl_state_t;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_SETUP = 3'b001,
    E_PULSE = 3'b010,
    E_HOLD = 3'b011,
    E_READ = 3'b100
  } eng_state_t;

endpackage

/* design/flash_pin_engine.sv */
// pin engine: runs one write-strobe or read cycle on the flash pins
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_pin_engine
  import flash_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  flash_cycle_if.engine cyc,
  output logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n
);

  eng_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [20:0] addr_q, addr_d;
  logic [7:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d;
  logic ce_n_q, ce_n_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q - 4'h1;
    addr_d = addr_q;
    dq_d = dq_q;
    dq_oe_d = dq_oe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      E_IDLE:
      begin
        cnt_d = cnt_q;
        // done_q guards against restarting on the request still high
        if (cyc.req && !done_q)
        begin
          addr_d = cyc.addr;
          dq_d = cyc.wdata;
          ce_n_d = 1'b0;
          if (cyc.write)
          begin
            dq_oe_d = 1'b1;
            cnt_d = 4'(`ADDR_SETUP_CYCLES);
            state_d = E_SETUP;
          end
          else
          begin
            oe_n_d = 1'b0;
            cnt_d = 4'(`READ_ACCESS_CYCLES);
            state_d = E_READ;
          end
        end
      end
      E_SETUP:
      begin
        if (cnt_q == 4'h1)
        begin
          we_n_d = 1'b0;
          cnt_d = 4'(`WE_PULSE_CYCLES);
          state_d = E_PULSE;
        end
      end
      E_PULSE:
      begin
        if (cnt_q == 4'h1)
        begin
          we_n_d = 1'b1;
          state_d = E_HOLD;
        end
      end
      E_HOLD:
      begin
        // address and data stay one cycle past the rising strobe
        dq_oe_d = 1'b0;
        ce_n_d = 1'b1;
        done_d = 1'b1;
        state_d = E_IDLE;
      end
      E_READ:
      begin
        if (cnt_q == 4'h1)
        begin
          rdata_d = flash_dq_i;
          oe_n_d = 1'b1;
          ce_n_d = 1'b1;
          done_d = 1'b1;
          state_d = E_IDLE;
        end
      end
      default:
      begin
        state_d = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= E_IDLE;
      cnt_q <= 4'h0;
      addr_q <= `ADDR_RESET;
      dq_q <= `WDATA_RESET;
      dq_oe_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign flash_addr = addr_q;
  assign flash_dq_o = dq_q;
  assign flash_dq_oe = dq_oe_q;
  assign chip_select_n = ce_n_q;
  assign output_enable_n = oe_n_q;
  assign write_enable_n = we_n_q;
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

endmodule
